// file: hdl/pmc_consts.svh
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// Register byte addresses (word aligned, full 32-bit map)
`define PMC_ADDR_MODE 32'hE01F_C0C0
`define PMC_ADDR_GATES 32'hE01F_C0C4
`define PMC_ADDR_STATUS 32'hE01F_C0C8

// Mode control field positions
`define PMC_BIT_LIGHT 0
`define PMC_BIT_DEEP 1
`define PMC_BIT_BO_SLEEP 2
`define PMC_BIT_BO_OFF 3
`define PMC_BIT_BO_RST_OFF 4

// Reset values
`define PMC_MODE_RST 8'h00
`define PMC_GATES_RST 32'h0018_17BE

// Oscillator restart settle time before clocks return
`define PMC_OSC_SETTLE_NS 2000
`define PMC_CLK_NS 40
`define PMC_OSC_SETTLE_CYC ((`PMC_OSC_SETTLE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)

`endif

// file: hdl/pmc_pkg.sv
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_LIGHT,
    PMC_DEEP,
    PMC_WAKE
  } pmc_state_e;

  // Wishbone classic slave request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pmc_wb_req_s;

  // Outputs towards core, oscillator and detector
  typedef struct packed {
    logic cpu_clk_en;
    logic osc_en;
    logic periph_clk_en;
    logic pin_hold;
    logic bo_enable;
    logic bo_reset_en;
    logic bo_wake_en;
  } pmc_ctl_s;
endpackage

// file: hdl/pmc_power_mode.sv
// What this block does
// (RULE_01) Light sleep halts execution until reset or interrupt arrives.
// (RULE_02) Light-sleep bit 0 stops only core clock; enabled interrupt resumes.
// (RULE_03) Deep sleep shuts the oscillator; no internal clock runs.
// (RULE_04) Deep sleep keeps core, peripheral and memory state unchanged.
// (RULE_05) Deep sleep freezes every output pin level.
// (RULE_06) Deep sleep ends on reset or clockless interrupt source.
// (RULE_07) Interrupt wake resumes with no instruction lost or repeated.
// (RULE_08) Two mode bits; writing one enters; both set means deep sleep.
// (RULE_09) Deep bit 1 stops clocks; external wake restarts, clears bit.
// (RULE_10) USB wake enable zero: deep-sleep set always accepted.
// (RULE_11) USB wake enable and clock-needed both one: deep set ignored.
// (RULE_12) Brown-out select bit 2 zero: detector active, reset wakes.
// (RULE_13) Reset values: mode 0x00, clock gates 0x0018_17BE.
// (RULE_14) Brown-out select one: detector sleeps, no wake source.
// (RULE_15) Global off bit 3 one: detector disabled always.
// (RULE_16) Reset off bit 4 one: second stage gives no chip reset.
// (RULE_17) Gate bit one enables peripheral clock, zero disables it.
// (RULE_18) Interrupt ending light sleep clears the light-sleep bit.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_power_mode #(
  parameter int SETTLE_CYC = `PMC_OSC_SETTLE_CYC,
  parameter logic [31:0] GATES_RST = `PMC_GATES_RST
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Wake and status inputs from outside the clock domain
  input wire logic irq_wake,
  input wire logic ext_irq_wake,
  input wire logic bo_reset_req,
  input wire logic usb_activity_wake_enable,
  input wire logic usb_clock_needed,
  // Core handshake, same clock
  input wire logic cpu_idle_ack,
  // Controls out
  output logic cpu_clk_en,
  output logic osc_en,
  output logic periph_clk_en,
  output logic pin_hold,
  output logic brownout_detector_en,
  output logic brownout_reset_en,
  output logic brownout_wake_en,
  output logic [31:0] peripheral_clock_gates,
  output logic wake_reset
);
  typedef struct packed {
    pmc_pkg::pmc_state_e state;
    logic [7:0] mode;
    logic [31:0] gates;
    logic [15:0] settle;
    pmc_pkg::pmc_ctl_s ctl;
    logic [31:0] gates_out;
    logic wake_reset;
  } pmc_top_s;

  pmc_top_s st_q;
  pmc_top_s st_d;
  pmc_pkg::pmc_wb_req_s req;
  logic wr_stb;
  logic [31:0] rd_word;
  logic [31:0] rdat;
  logic ack;
  logic irq_s;
  logic ext_s;
  logic bor_s;
  logic usbw_s;
  logic usbn_s;
  logic [7:0] wmode;
  logic deep_blocked;
  logic bo_wake;

  // Bus request bundle
  always_comb begin
    req.cyc = wb_cyc_i;
    req.stb = wb_stb_i;
    req.we = wb_we_i;
    req.adr = wb_adr_i;
    req.sel = wb_sel_i;
    req.dat = wb_dat_i;
  end

  pmc_wb_slave u_wb (
    .ref_clk(ref_clk),
    .reset(reset),
    .req(req),
    .ack(ack),
    .rdat(rdat),
    .wr_stb(wr_stb),
    .rd_word(rd_word)
  );

  // Asynchronous inputs pass three synchroniser flops and an output flop each
  pmc_sync3 u_s_irq (.ref_clk(ref_clk), .reset(reset), .din(irq_wake),
    .dout(irq_s));
  pmc_sync3 u_s_ext (.ref_clk(ref_clk), .reset(reset), .din(ext_irq_wake),
    .dout(ext_s));
  pmc_sync3 u_s_bor (.ref_clk(ref_clk), .reset(reset), .din(bo_reset_req),
    .dout(bor_s));
  pmc_sync3 u_s_usbw (.ref_clk(ref_clk), .reset(reset),
    .din(usb_activity_wake_enable), .dout(usbw_s));
  pmc_sync3 u_s_usbn (.ref_clk(ref_clk), .reset(reset),
    .din(usb_clock_needed), .dout(usbn_s));

  // Read mux; unmapped words read zero, reserved bits zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      `PMC_ADDR_MODE: rd_word = {24'h00_0000, 3'b000, st_q.mode[4:0]};
      `PMC_ADDR_GATES: rd_word = st_q.gates;
      `PMC_ADDR_STATUS: rd_word = {30'h0000_0000, st_q.state};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Merged write value for the mode byte, lane 0 only
  always_comb begin
    wmode = st_q.mode;
    if (wr_stb && wb_adr_i == `PMC_ADDR_MODE && wb_sel_i[0]) begin
      wmode = {3'b000, wb_dat_i[4:0]};
    end
  end

  // USB activity that needs a clock blocks deep sleep
  // (RULE_10) deep set accepted
  // (RULE_11) deep set refused
  assign deep_blocked = usbw_s && usbn_s;

  // Brown-out reset may wake only when detector runs through sleep
  // (RULE_12) detector wake path
  // (RULE_14) no wake when sleeping
  assign bo_wake = bor_s && !st_q.mode[`PMC_BIT_BO_OFF]
    && !st_q.mode[`PMC_BIT_BO_SLEEP] && !st_q.mode[`PMC_BIT_BO_RST_OFF];

  // Next state
  always_comb begin
    st_d = st_q;
    st_d.wake_reset = 1'b0;
    // Register writes
    if (wr_stb && wb_adr_i == `PMC_ADDR_MODE && wb_sel_i[0]) begin
      st_d.mode = wmode;
      // (RULE_11) refuse deep bit
      if (deep_blocked) begin
        st_d.mode[`PMC_BIT_DEEP] = st_q.mode[`PMC_BIT_DEEP];
      end
    end
    // (RULE_17) byte-lane gate writes
    if (wr_stb && wb_adr_i == `PMC_ADDR_GATES) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          st_d.gates[8*i +: 8] = wb_dat_i[8*i +: 8];
        end
      end
    end
    case (st_q.state)
      pmc_pkg::PMC_RUN: begin
        // (RULE_08) deep wins over light
        if (st_d.mode[`PMC_BIT_DEEP]) begin
          st_d.state = pmc_pkg::PMC_DEEP;
        end else if (st_d.mode[`PMC_BIT_LIGHT]) begin
          st_d.state = pmc_pkg::PMC_LIGHT;
        end
      end
      pmc_pkg::PMC_LIGHT: begin
        // (RULE_02) any enabled interrupt resumes
        if (irq_s || ext_s) begin
          // (RULE_18) clear light bit
          st_d.mode[`PMC_BIT_LIGHT] = 1'b0;
          st_d.state = pmc_pkg::PMC_RUN;
        end else if (st_d.mode[`PMC_BIT_DEEP]) begin
          st_d.state = pmc_pkg::PMC_DEEP;
        end
      end
      pmc_pkg::PMC_DEEP: begin
        // (RULE_06) clockless wake sources
        // (RULE_09) external wake clears deep bit
        if (ext_s) begin
          st_d.mode[`PMC_BIT_DEEP] = 1'b0;
          st_d.mode[`PMC_BIT_LIGHT] = 1'b0;
          st_d.settle = 16'(SETTLE_CYC);
          st_d.state = pmc_pkg::PMC_WAKE;
        end else if (bo_wake) begin
          st_d.wake_reset = 1'b1;
          st_d.mode = `PMC_MODE_RST;
          st_d.state = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_WAKE: begin
        // Oscillator settles before clocks return
        if (st_q.settle <= 16'd1) begin
          st_d.state = pmc_pkg::PMC_RUN;
        end else begin
          st_d.settle = st_q.settle - 16'd1;
        end
      end
      default: st_d.state = pmc_pkg::PMC_RUN;
    endcase
    // Outputs derived from next state, registered
    // (RULE_01) halt core in light sleep
    // (RULE_07) core gated only at idle boundary
    // Once stopped the gate stays shut: the idle flag drops as the core
    // starts its next instruction, which must not reopen the clock
    st_d.ctl.cpu_clk_en = (st_d.state == pmc_pkg::PMC_RUN)
      || (st_q.ctl.cpu_clk_en && !cpu_idle_ack);
    // (RULE_03) oscillator off
    // Waits for the core gate, so no instruction is cut in half
    st_d.ctl.osc_en = !(st_d.state == pmc_pkg::PMC_DEEP
      && !st_d.ctl.cpu_clk_en);
    // (RULE_04) all clocks stop, state retained
    st_d.ctl.periph_clk_en = (st_d.state == pmc_pkg::PMC_RUN)
      || (st_d.state == pmc_pkg::PMC_LIGHT);
    // (RULE_05) pins frozen
    st_d.ctl.pin_hold = (st_d.state == pmc_pkg::PMC_DEEP)
      || (st_d.state == pmc_pkg::PMC_WAKE);
    // (RULE_15) detector globally off
    st_d.ctl.bo_enable = !st_d.mode[`PMC_BIT_BO_OFF]
      && !(st_d.state == pmc_pkg::PMC_DEEP
      && st_d.mode[`PMC_BIT_BO_SLEEP]);
    // (RULE_16) second stage reset disabled
    st_d.ctl.bo_reset_en = st_d.ctl.bo_enable
      && !st_d.mode[`PMC_BIT_BO_RST_OFF];
    st_d.ctl.bo_wake_en = st_d.ctl.bo_reset_en
      && !st_d.mode[`PMC_BIT_BO_SLEEP];
    // (RULE_17) gate outputs follow register
    st_d.gates_out = st_d.gates;
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q.state <= pmc_pkg::PMC_RUN;
      // (RULE_13) reset values
      st_q.mode <= `PMC_MODE_RST;
      st_q.gates <= GATES_RST;
      st_q.settle <= 16'h0000;
      st_q.ctl <= 7'h77;
      st_q.gates_out <= GATES_RST;
      st_q.wake_reset <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign wb_dat_o = rdat;
  assign wb_ack_o = ack;
  assign cpu_clk_en = st_q.ctl.cpu_clk_en;
  assign osc_en = st_q.ctl.osc_en;
  assign periph_clk_en = st_q.ctl.periph_clk_en;
  assign pin_hold = st_q.ctl.pin_hold;
  assign brownout_detector_en = st_q.ctl.bo_enable;
  assign brownout_reset_en = st_q.ctl.bo_reset_en;
  assign brownout_wake_en = st_q.ctl.bo_wake_en;
  assign peripheral_clock_gates = st_q.gates_out;
  assign wake_reset = st_q.wake_reset;
endmodule // pmc_power_mode
`default_nettype wire

// file: hdl/pmc_sync3.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser, change taken when stages two and three agree
module pmc_sync3 (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Data
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic [2:0] sh;
    logic out;
  } pmc_sync_s;
  pmc_sync_s st_q;
  pmc_sync_s st_d;

  // Shift and agree
  always_comb begin
    st_d = st_q;
    st_d.sh = {st_q.sh[1:0], din};
    if (st_q.sh[1] == st_q.sh[2]) begin
      st_d.out = st_q.sh[2];
    end
  end

  // Register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.out;
endmodule // pmc_sync3
`default_nettype wire

// file: hdl/pmc_wb_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Classic Wishbone slave front end: one-cycle ack, registered read data
module pmc_wb_slave (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Bus request
  input wire pmc_pkg::pmc_wb_req_s req,
  output logic ack,
  output logic [31:0] rdat,
  // Register side
  output logic wr_stb,
  input wire logic [31:0] rd_word
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
  } pmc_wbs_s;
  pmc_wbs_s st_q;
  pmc_wbs_s st_d;
  logic take;

  // Answer once per request, drop ack the cycle after
  always_comb begin
    take = req.cyc && req.stb && !st_q.ack;
    st_d = st_q;
    st_d.ack = take;
    st_d.rdat = take ? rd_word : st_q.rdat;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Write lands on the ack edge
  assign wr_stb = st_q.ack && req.cyc && req.stb && req.we;
  assign ack = st_q.ack;
  assign rdat = st_q.rdat;
endmodule // pmc_wb_slave
`default_nettype wire

// file: verif/pmc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
  // Clock, reset and gate
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cpu_clk_en,
  input wire logic slow,
  // Boundary flag and retired count
  output logic cpu_idle_ack,
  output int retired
);
  int ph;
  // whole instructions only
  // A gated clock freezes the phase, so nothing retires while asleep
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ph <= 0;
      retired <= 0;
    end else if (cpu_clk_en) begin
      ph <= cpu_idle_ack ? 0 : ph + 1;
      retired <= retired + (cpu_idle_ack ? 1 : 0);
    end
  end
  // Slow instructions take four cycles
  assign cpu_idle_ack = ph >= (slow ? 3 : 1);
endmodule // pmc_core_model
`default_nettype wire

// file: verif/pmc_power_mode_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Core and wake sources
  input wire logic cpu_idle_ack,
  input wire logic irq_wake,
  input wire logic ext_irq_wake,
  // Controls
  input wire logic cpu_clk_en,
  input wire logic osc_en,
  input wire logic periph_clk_en,
  input wire logic pin_hold,
  input wire logic brownout_wake_en,
  input wire logic [31:0] peripheral_clock_gates,
  input wire logic wake_reset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Sleep states seen from the outputs
  sequence s_light;
    !cpu_clk_en && osc_en && !pin_hold;
  endsequence
  sequence s_deep;
    !osc_en && pin_hold;
  endsequence
  // Properties
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  property p_edge;
    $fell(cpu_clk_en) && osc_en |-> $past(cpu_idle_ack) && periph_clk_en;
  endproperty
  property p_deep;
    !osc_en |-> !cpu_clk_en && !periph_clk_en && pin_hold;
  endproperty
  property p_hold;
    pin_hold |-> $stable(peripheral_clock_gates);
  endproperty
  property p_irq;
    s_light ##0 irq_wake |-> ##[1:8] cpu_clk_en;
  endproperty
  property p_ext;
    s_deep ##0 ext_irq_wake |-> ##[1:20] cpu_clk_en;
  endproperty
  property p_osc;
    $rose(osc_en) && !wake_reset |-> !cpu_clk_en;
  endproperty
  property p_bo;
    wake_reset |-> !$past(osc_en) && $past(brownout_wake_en) ##1 !wake_reset;
  endproperty
  property p_run;
    cpu_clk_en |-> osc_en;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus ack not a single pulse");
  a_edge: assert property (p_edge)
    else $error("core clock stopped off a boundary");
  a_deep: assert property (p_deep)
    else $error("deep sleep outputs wrong");
  a_hold: assert property (p_hold)
    else $error("gates changed in deep sleep");
  a_irq: assert property (p_irq)
    else $error("no resume from light sleep");
  a_ext: assert property (p_ext)
    else $error("no resume from deep sleep");
  a_osc: assert property (p_osc)
    else $error("core clock before oscillator");
  a_bo: assert property (p_bo)
    else $error("brown-out wake pulse wrong");
  a_run: assert property (p_run)
    else $error("core clock without oscillator");
endmodule // pmc_power_mode_chk
bind pmc_power_mode pmc_power_mode_chk pmc_power_mode_chk_inst (
  .ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cpu_idle_ack,
  .irq_wake, .ext_irq_wake, .cpu_clk_en, .osc_en, .periph_clk_en,
  .pin_hold, .brownout_wake_en, .peripheral_clock_gates, .wake_reset);
`default_nettype wire

// file: verif/pmc_power_mode_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_power_mode_tb;
  logic ref_clk = 0, reset = 1, slow = 0, ack, idle, wr;
  logic [4:0] in = 5'h00;
  logic [31:0] r, dat, gates, rnd = 32'h0000_0037, gm;
  pmc_pkg::pmc_wb_req_s q = '0;
  wire pmc_pkg::pmc_ctl_s c;
  wire [2:0] ob = {wr, c.osc_en, c.cpu_clk_en};
  int n_errors = 0, tests_run = 0, ret, k, n;
  pmc_power_mode #(.SETTLE_CYC(3)) pmc_power_mode_inst (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(q.cyc), .wb_stb_i(q.stb),
    .wb_we_i(q.we), .wb_adr_i(q.adr), .wb_sel_i(q.sel), .wb_dat_i(q.dat),
    .wb_dat_o(dat), .wb_ack_o(ack), .irq_wake(in[4]), .ext_irq_wake(in[3]),
    .bo_reset_req(in[2]), .usb_activity_wake_enable(in[1]),
    .usb_clock_needed(in[0]), .cpu_idle_ack(idle), .cpu_clk_en(c.cpu_clk_en),
    .osc_en(c.osc_en), .periph_clk_en(c.periph_clk_en), .pin_hold(c.pin_hold),
    .brownout_detector_en(c.bo_enable), .brownout_reset_en(c.bo_reset_en),
    .brownout_wake_en(c.bo_wake_en), .peripheral_clock_gates(gates),
    .wake_reset(wr));
  pmc_core_model pmc_core_model_inst (.ref_clk(ref_clk), .reset(reset),
    .cpu_clk_en(c.cpu_clk_en), .slow(slow), .cpu_idle_ack(idle),
    .retired(ret));
  // Clock
  initial forever #20 ref_clk = ~ref_clk;
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task finish_test;
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // Ran out of patience: count it and stop
  task tmo(input int i);
    if (i >= 60) begin
      n_errors++;
      finish_test();
    end
  endtask
  // Classic single cycle, held until ack is sampled
  task wb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    int i;
    @(posedge ref_clk);
    q <= {2'b11, w, a, s, d};
    for (i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      if (ack === 1'b1) break;
    end
    tmo(i);
    r = dat;
    q.cyc <= 0;
    q.stb <= 0;
  endtask
  task waitv(input int j, input logic v);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      if (ob[j] === v) break;
    end
    tmo(i);
  endtask
  task rst_chk(input int m);
    reset <= 1;
    repeat (m) @(posedge ref_clk);
    reset <= 0;
    gm = 32'h0018_17BE;
    wb(0, `PMC_ADDR_MODE, 0, 4'hF);
    chk("mode rst", r, 0);
    wb(0, `PMC_ADDR_GATES, 0, 4'hF);
    chk("gates rst", r, gm);
    wb(0, `PMC_ADDR_MODE + 16, 0, 4'hF);
    chk("unmapped", r, 0);
  endtask
  // Enter deep sleep, then wake by ext (3) or brown-out (2)
  task deep(input logic [7:0] m, input int w);
    wb(1, `PMC_ADDR_MODE, m, 4'hF);
    waitv(1, 0);
    chk("pins", c.pin_hold, 1);
    chk("kept", gates, gm);
    wb(0, `PMC_ADDR_STATUS, 0, 4'hF);
    chk("state deep", r, 2);
    chk("bo wake", c.bo_wake_en, !m[2]);
    chk("bo pd", c.bo_enable, !m[2]);
    in[w] <= 1;
    if (w == 2 && m[2]) begin
      repeat (20) @(posedge ref_clk);
      chk("bo sleep", c.osc_en, 0);
      w = 3;
      in <= 5'h08;
    end
    waitv(w == 2 ? 2 : 0, 1);
    in <= 5'h00;
    wb(0, `PMC_ADDR_MODE, 0, 4'hF);
    chk("mode wake", r, w == 2 ? 0 : m & 8'h1C);
  endtask
  // Main sequence
  initial begin
    rst_chk(10);
    for (k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      slow <= rnd[8];
      wb(1, `PMC_ADDR_GATES, rnd, rnd[3:0]);
      for (int j = 0; j < 4; j++) if (rnd[j]) gm[8*j +: 8] = rnd[8*j +: 8];
      wb(0, `PMC_ADDR_GATES, 0, 4'hF);
      chk("gates rd", r, gm);
      chk("gates out", gates, gm);
    end
    for (k = 0; k < 2; k++) begin
      wb(1, `PMC_ADDR_MODE, 1, 4'hF);
      waitv(0, 0);
      chk("periph", c.periph_clk_en, 1);
      wb(0, `PMC_ADDR_STATUS, 0, 4'hF);
      chk("state light", r, 1);
      n = ret;
      repeat (6) @(posedge ref_clk);
      chk("halt", ret, n);
      in[4] <= 1;
      waitv(0, 1);
      in[4] <= 0;
      wb(0, `PMC_ADDR_MODE, 0, 4'hF);
      chk("light clr", r, 0);
    end
    deep(3, 3);
    deep(2, 2);
    deep(6, 2);
    wb(1, `PMC_ADDR_MODE, 8'h08, 4'hF);
    repeat (2) @(posedge ref_clk);
    chk("bo off", c.bo_enable, 0);
    wb(1, `PMC_ADDR_MODE, 8'h10, 4'hF);
    repeat (2) @(posedge ref_clk);
    chk("bo rst", c.bo_reset_en, 0);
    in <= 5'h03;
    repeat (4) @(posedge ref_clk);
    wb(1, `PMC_ADDR_MODE, 2, 4'hF);
    repeat (10) @(posedge ref_clk);
    chk("usb osc", c.osc_en, 1);
    wb(0, `PMC_ADDR_MODE, 0, 4'hF);
    chk("usb mode", r, 0);
    in <= 5'h01;
    repeat (4) @(posedge ref_clk);
    deep(2, 3);
    rst_chk(4);
    finish_test();
  end
endmodule // pmc_power_mode_tb
`default_nettype wire
